// File: tlm_pkg.sv
package tlm_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned TICK_NS            = 1000000;
	localparam int unsigned TICK_CYC           = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_S        = 1000;
	localparam int unsigned STATE_TIMEOUT_S    = 100;
	localparam int unsigned STATE_TIMEOUT_TICKS = STATE_TIMEOUT_S * TICKS_PER_S;
	localparam int unsigned LOCK_QUAL_S        = 1;
	localparam int unsigned LOCK_QUAL_TICKS    = LOCK_QUAL_S * TICKS_PER_S;
	localparam int unsigned SLEW_WIN_NS        = 1326000;
	localparam int unsigned SLEW_WIN_CYC       = SLEW_WIN_NS / CLK_PERIOD_NS;
	localparam int unsigned SLEW_STEP_NS       = 81;
	localparam int unsigned FREQ_LIMIT_BUILDOUT_PPM = 30;

	// ----------------------------------------------------------------
	// Widths, fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FREQ_W             = 19;
	localparam int unsigned PHASE_W            = 16;
	localparam int unsigned STATE_CODE_W       = 3;
	localparam int unsigned INPUT_MODE_MAN_HOLD_BIT = 4;
	localparam int unsigned HOLD_MODE_AVG_BIT  = 7;
	localparam int unsigned HOLD_MODE_FAST_BIT = 6;
	localparam int unsigned FILT_SHIFT_FAST    = 12;
	localparam int unsigned FILT_SHIFT_SLOW    = 16;
	localparam logic [7:0]  INPUT_MODE_RST     = 8'h00;
	localparam logic [7:0]  HOLD_MODE_RST      = 8'h80;

	// ----------------------------------------------------------------
	// Main loop states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_FREE_RUN,
		ST_HOLDOVER,
		ST_LOCKED,
		ST_PRE_LOCKED,
		ST_PRE_LOCKED2,
		ST_LOST_PHASE
	} tlm_state_e;

endpackage

// File: tlm_avg_filter.sv
`timescale 1ns/1ps

module tlm_avg_filter #(
	parameter int unsigned P_W          = tlm_pkg::FREQ_W,
	parameter int unsigned P_SHIFT_FAST = tlm_pkg::FILT_SHIFT_FAST,
	parameter int unsigned P_SHIFT_SLOW = tlm_pkg::FILT_SHIFT_SLOW
) (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_en,
	input  wire logic                  i_fast,
	input  wire logic signed [P_W-1:0] i_sample,
	output logic signed [P_W-1:0]      o_avg
);

	localparam int unsigned AW = P_W + P_SHIFT_SLOW;

	typedef struct packed {
		logic signed [AW-1:0] acc;
	} tlm_filt_s;

	tlm_filt_s st_reg;
	tlm_filt_s st_next;
	logic signed [AW:0] err;

	// ----------------------------------------------------------------
	// First-order IIR: acc += (x - acc) >> k
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		err = (AW+1)'($signed({i_sample, {P_SHIFT_SLOW{1'b0}}})) - (AW+1)'(st_reg.acc);
		if (i_en) begin
			if (i_fast) begin
				st_next.acc = st_reg.acc + AW'(err >>> P_SHIFT_FAST);
			end else begin
				st_next.acc = st_reg.acc + AW'(err >>> P_SHIFT_SLOW);
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_avg = st_reg.acc[AW-1:P_SHIFT_SLOW];

endmodule

// File: tlm_mode_ctrl.sv
`timescale 1ns/1ps

module tlm_mode_ctrl #(
	parameter int unsigned P_TICK_CYC      = tlm_pkg::TICK_CYC,
	parameter int unsigned P_TIMEOUT_TICKS = tlm_pkg::STATE_TIMEOUT_TICKS,
	parameter int unsigned P_LOCK_TICKS    = tlm_pkg::LOCK_QUAL_TICKS,
	parameter int unsigned P_SLEW_WIN_CYC  = tlm_pkg::SLEW_WIN_CYC
) (
	input  wire logic                                      i_ref_clk,
	input  wire logic                                      i_rst_n,
	input  wire logic                                      i_ce,
	input  wire logic                                      i_force_en,
	input  wire logic [tlm_pkg::STATE_CODE_W-1:0]          i_force_code,
	input  wire logic [7:0]                                i_input_mode_cfg,
	input  wire logic [7:0]                                i_holdover_mode_cfg,
	input  wire logic                                      i_phase_buildout_en,
	input  wire logic [7:0]                                i_freq_limit_ppm,
	input  wire logic                                      i_ref_selected,
	input  wire logic                                      i_src_valid,
	input  wire logic                                      i_standby_avail,
	input  wire logic                                      i_phase_locked,
	input  wire logic                                      i_bucket_serious,
	input  wire logic signed [tlm_pkg::FREQ_W-1:0]         i_nominal_cal,
	input  wire logic signed [tlm_pkg::FREQ_W-1:0]         i_loop_integral,
	input  wire logic signed [tlm_pkg::FREQ_W-1:0]         i_loop_prop,
	input  wire logic signed [tlm_pkg::FREQ_W-1:0]         i_man_holdover_freq,
	input  wire logic signed [tlm_pkg::PHASE_W-1:0]        i_phase_target,
	input  wire logic                                      i_aux_lock,
	input  wire logic signed [tlm_pkg::FREQ_W-1:0]         i_aux_loop_freq,
	output logic [tlm_pkg::STATE_CODE_W-1:0]               o_main_loop_state_code,
	output logic                                           o_track_ref,
	output logic                                           o_ref_disqualify,
	output logic                                           o_phase_alarm,
	output logic signed [tlm_pkg::FREQ_W-1:0]              o_freq_word,
	output logic signed [tlm_pkg::FREQ_W-1:0]              o_avg_freq,
	output logic signed [tlm_pkg::PHASE_W-1:0]             o_phase_offset,
	output logic                                           o_aux_locked,
	output logic signed [tlm_pkg::FREQ_W-1:0]              o_aux_freq_word
);

	localparam int unsigned FW = tlm_pkg::FREQ_W;
	localparam int unsigned PW = tlm_pkg::PHASE_W;
	localparam logic signed [PW:0] SLEW_STEP = (PW+1)'(tlm_pkg::SLEW_STEP_NS);

	typedef struct packed {
		tlm_pkg::tlm_state_e st;
		logic [31:0]         tick_cnt;
		logic [31:0]         dwell;
		logic [31:0]         lockq;
		logic [31:0]         win_cnt;
		logic                disq;
		logic                alarm;
		logic signed [FW-1:0] hold_freq;
		logic signed [FW-1:0] freq;
		logic signed [PW-1:0] phase;
		logic                aux_locked;
		logic signed [FW-1:0] aux_freq;
	} tlm_ctrl_s;

	tlm_ctrl_s r_reg;
	tlm_ctrl_s r_next;

	logic              tick;
	logic              qual;
	logic              timeout;
	logic              man_hold;
	logic              avg_hold;
	logic              fast_avg;
	logic              limit_on;
	logic              win_end;
	logic              filt_en;
	logic signed [PW:0] pdiff;
	logic signed [FW-1:0] avg_freq;

	assign tick     = r_reg.tick_cnt == 32'(P_TICK_CYC - 1);
	assign qual     = r_reg.lockq == 32'(P_LOCK_TICKS) && i_ref_selected;
	assign timeout  = r_reg.dwell >= 32'(P_TIMEOUT_TICKS);
	assign man_hold = i_input_mode_cfg[tlm_pkg::INPUT_MODE_MAN_HOLD_BIT];
	assign avg_hold = i_holdover_mode_cfg[tlm_pkg::HOLD_MODE_AVG_BIT];
	assign fast_avg = i_holdover_mode_cfg[tlm_pkg::HOLD_MODE_FAST_BIT];
	assign limit_on = i_phase_buildout_en || i_freq_limit_ppm < 8'(tlm_pkg::FREQ_LIMIT_BUILDOUT_PPM);
	assign win_end  = r_reg.win_cnt == 32'(P_SLEW_WIN_CYC - 1);
	assign pdiff    = (PW+1)'(i_phase_target) - (PW+1)'(r_reg.phase);
	assign filt_en  = i_ce && tick && r_reg.st == tlm_pkg::ST_LOCKED;

	// ----------------------------------------------------------------
	// Holdover averaging filter
	// ----------------------------------------------------------------
	tlm_avg_filter #(
		.P_W          (FW),
		.P_SHIFT_FAST (tlm_pkg::FILT_SHIFT_FAST),
		.P_SHIFT_SLOW (tlm_pkg::FILT_SHIFT_SLOW)
	) u_avg (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_en      (filt_en),
		.i_fast    (fast_avg),
		.i_sample  (i_loop_integral),
		.o_avg     (avg_freq)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.disq = 1'b0;
		r_next.alarm = 1'b0;
		r_next.tick_cnt = tick ? 32'h0 : r_reg.tick_cnt + 32'h1;
		if (!i_phase_locked) begin
			r_next.lockq = 32'h0;
		end else if (tick && r_reg.lockq != 32'(P_LOCK_TICKS)) begin
			r_next.lockq = r_reg.lockq + 32'h1;
		end
		if (tick && !timeout) begin
			r_next.dwell = r_reg.dwell + 32'h1;
		end
		if (i_force_en) begin
			unique case (i_force_code)
				3'h0: r_next.st = tlm_pkg::ST_FREE_RUN;
				3'h1: r_next.st = tlm_pkg::ST_HOLDOVER;
				3'h2: r_next.st = tlm_pkg::ST_LOCKED;
				3'h3: r_next.st = tlm_pkg::ST_PRE_LOCKED;
				3'h4: r_next.st = tlm_pkg::ST_PRE_LOCKED2;
				3'h5: r_next.st = tlm_pkg::ST_LOST_PHASE;
				default: r_next.st = r_reg.st;
			endcase
		end else begin
			unique case (r_reg.st)
				tlm_pkg::ST_FREE_RUN: begin
					if (i_ref_selected) begin
						r_next.st = tlm_pkg::ST_PRE_LOCKED;
					end
				end
				tlm_pkg::ST_PRE_LOCKED: begin
					if (qual) begin
						r_next.st = tlm_pkg::ST_LOCKED;
					end else if (timeout) begin
						r_next.st = tlm_pkg::ST_FREE_RUN;
						r_next.disq = 1'b1;
						r_next.alarm = 1'b1;
					end
				end
				tlm_pkg::ST_LOCKED: begin
					if (!i_src_valid && !i_standby_avail) begin
						r_next.st = tlm_pkg::ST_HOLDOVER;
					end else if (!i_phase_locked) begin
						r_next.st = tlm_pkg::ST_LOST_PHASE;
					end
				end
				tlm_pkg::ST_LOST_PHASE: begin
					if (!i_src_valid && !i_standby_avail) begin
						r_next.st = tlm_pkg::ST_HOLDOVER;
					end else if (qual) begin
						r_next.st = tlm_pkg::ST_LOCKED;
					end else if (i_bucket_serious || timeout) begin
						r_next.disq = 1'b1;
						r_next.alarm = timeout;
						r_next.st = i_standby_avail ? tlm_pkg::ST_PRE_LOCKED2 : tlm_pkg::ST_HOLDOVER;
					end
				end
				tlm_pkg::ST_HOLDOVER: begin
					if (i_ref_selected && i_src_valid) begin
						r_next.st = tlm_pkg::ST_PRE_LOCKED2;
					end
				end
				tlm_pkg::ST_PRE_LOCKED2: begin
					if (!i_src_valid && !i_standby_avail) begin
						r_next.st = tlm_pkg::ST_HOLDOVER;
					end else if (qual) begin
						r_next.st = tlm_pkg::ST_LOCKED;
					end else if (timeout) begin
						r_next.st = tlm_pkg::ST_HOLDOVER;
						r_next.disq = 1'b1;
						r_next.alarm = 1'b1;
					end
				end
			endcase
		end
		if (r_next.st != r_reg.st) begin
			r_next.dwell = 32'h0;
		end
		// Integral value captured on holdover entry, proportional path dropped
		if (r_next.st == tlm_pkg::ST_HOLDOVER && r_reg.st != tlm_pkg::ST_HOLDOVER) begin
			r_next.hold_freq = i_loop_integral;
		end
		// Output frequency selected by present state
		unique case (r_reg.st)
			tlm_pkg::ST_FREE_RUN: r_next.freq = i_nominal_cal;
			tlm_pkg::ST_HOLDOVER: begin
				if (man_hold) begin
					r_next.freq = i_man_holdover_freq;
				end else if (avg_hold) begin
					r_next.freq = avg_freq;
				end else begin
					r_next.freq = r_reg.hold_freq;
				end
			end
			default: r_next.freq = FW'(i_loop_integral + i_loop_prop);
		endcase
		// Output phase slew limiting
		r_next.win_cnt = win_end ? 32'h0 : r_reg.win_cnt + 32'h1;
		if (!limit_on) begin
			r_next.phase = i_phase_target;
		end else if (win_end) begin
			if (pdiff > SLEW_STEP) begin
				r_next.phase = r_reg.phase + PW'(tlm_pkg::SLEW_STEP_NS);
			end else if (pdiff < -SLEW_STEP) begin
				r_next.phase = r_reg.phase - PW'(tlm_pkg::SLEW_STEP_NS);
			end else begin
				r_next.phase = i_phase_target;
			end
		end
		// Aux loop: zero-offset holdover or locked
		r_next.aux_locked = i_aux_lock;
		r_next.aux_freq = i_aux_lock ? i_aux_loop_freq : '0;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			r_reg <= '0;
			r_reg.st <= tlm_pkg::ST_FREE_RUN;
		end else if (i_ce) begin
			r_reg <= r_next;
		end
	end

	assign o_main_loop_state_code = tlm_pkg::STATE_CODE_W'(r_reg.st);
	assign o_track_ref = r_reg.st != tlm_pkg::ST_FREE_RUN && r_reg.st != tlm_pkg::ST_HOLDOVER;
	assign o_ref_disqualify = r_reg.disq;
	assign o_phase_alarm = r_reg.alarm;
	assign o_freq_word = r_reg.freq;
	assign o_avg_freq = avg_freq;
	assign o_phase_offset = r_reg.phase;
	assign o_aux_locked = r_reg.aux_locked;
	assign o_aux_freq_word = r_reg.aux_freq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	a_slew_step_bound: assert property (
		i_ce && limit_on |=> (o_phase_offset - $past(o_phase_offset) <= 81)
			&& ($past(o_phase_offset) - o_phase_offset <= 81))
		else $error("phase step above limit");
	a_state_code_legal: assert property (o_main_loop_state_code < 3'h6)
		else $error("illegal state code");
	a_forced_follow: assert property (
		i_ce && i_force_en && i_force_code < 3'h6 |=> o_main_loop_state_code == $past(i_force_code))
		else $error("forced state not taken");
	a_free_freq_src: assert property (
		i_ce && r_reg.st == tlm_pkg::ST_FREE_RUN |=> o_freq_word == $past(i_nominal_cal))
		else $error("free-run frequency not calibration value");
	a_free_to_pre: assert property (
		i_ce && !i_force_en && r_reg.st == tlm_pkg::ST_FREE_RUN && i_ref_selected
			|=> r_reg.st == tlm_pkg::ST_PRE_LOCKED)
		else $error("no pre-locked after selection");
	a_pre_timeout_exit: assert property (
		i_ce && !i_force_en && r_reg.st == tlm_pkg::ST_PRE_LOCKED && timeout && !qual
			|=> r_reg.st == tlm_pkg::ST_FREE_RUN && o_phase_alarm && o_ref_disqualify)
		else $error("pre-locked timeout mishandled");
	a_locked_entry_qual: assert property (
		r_reg.st == tlm_pkg::ST_LOCKED && $past(r_reg.st) != tlm_pkg::ST_LOCKED && !$past(i_force_en)
			|-> $past(qual))
		else $error("locked without qualified lock");
	a_lost_on_unlock: assert property (
		i_ce && !i_force_en && r_reg.st == tlm_pkg::ST_LOCKED && !i_phase_locked && i_src_valid
			|=> r_reg.st == tlm_pkg::ST_LOST_PHASE)
		else $error("lost-phase not entered");
	a_lost_disq_route: assert property (
		i_ce && !i_force_en && r_reg.st == tlm_pkg::ST_LOST_PHASE && i_src_valid && !qual && i_bucket_serious
			|=> o_ref_disqualify && r_reg.st == ($past(i_standby_avail) ? tlm_pkg::ST_PRE_LOCKED2
				: tlm_pkg::ST_HOLDOVER))
		else $error("lost-phase disqualify routed wrongly");
	a_inst_hold_freeze: assert property (
		i_ce && r_reg.st == tlm_pkg::ST_HOLDOVER && !man_hold && !avg_hold |=> o_freq_word == $past(r_reg.hold_freq))
		else $error("instantaneous holdover not frozen");
	a_aux_zero_hold: assert property (!o_aux_locked |-> o_aux_freq_word == '0)
		else $error("aux holdover offset not zero");

	c_reach_locked: cover property (r_reg.st == tlm_pkg::ST_PRE_LOCKED ##1 r_reg.st == tlm_pkg::ST_LOCKED);
	c_lost_to_hold: cover property (r_reg.st == tlm_pkg::ST_LOST_PHASE ##1 r_reg.st == tlm_pkg::ST_HOLDOVER);
	c_hold_to_pre2: cover property (r_reg.st == tlm_pkg::ST_HOLDOVER ##1 r_reg.st == tlm_pkg::ST_PRE_LOCKED2);
	c_alarm_pulse: cover property (o_phase_alarm);

endmodule

// File: tlm_ref_model.sv
`timescale 1ns/1ps

module tlm_ref_model (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	input  wire logic i_want_sel,
	input  wire logic i_want_valid,
	input  wire logic i_want_lock,
	input  wire logic i_disq,
	output logic      o_ref_selected,
	output logic      o_src_valid,
	output logic      o_phase_locked
);
	// ----------------------------------------------------------------
	// Selection and lock detector model
	// ----------------------------------------------------------------
	logic want_reg;
	logic sel_reg;

	// Selection withdrawn while a disqualify pulse stands
	assign o_ref_selected = sel_reg && !i_disq;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			want_reg       <= 1'b0;
			sel_reg        <= 1'b0;
			o_src_valid    <= 1'b0;
			o_phase_locked <= 1'b0;
		end else begin
			want_reg    <= i_want_sel;
			o_src_valid <= i_want_valid;
			// Disqualified reference dropped; a new pick needs a fresh request
			if (i_disq) begin
				sel_reg <= 1'b0;
			end else if (i_want_sel && !want_reg) begin
				sel_reg <= 1'b1;
			end else if (!i_want_sel) begin
				sel_reg <= 1'b0;
			end
			// Lock only reported on a selected reference
			o_phase_locked <= i_want_lock && o_ref_selected && !i_disq;
		end
	end
endmodule

// File: tb_top.sv
`timescale 1ns/1ps

module tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct {
		logic [7:0]  im;
		logic [7:0]  hm;
		logic [18:0] f;
	} tlm_row_s;

	logic        clk        = 1'b0;
	logic        rst_n      = 1'b0;
	logic        ce         = 1'b1;
	logic        force_en   = 1'b0;
	logic [2:0]  force_code = 3'h0;
	logic [7:0]  in_mode    = 8'h00;
	logic [7:0]  hold_mode  = 8'h00;
	logic        buildout_en = 1'b0;
	logic [7:0]  freq_lim   = 8'h50;
	logic        want_sel   = 1'b0;
	logic        want_valid = 1'b1;
	logic        want_lock  = 1'b0;
	logic        standby    = 1'b0;
	logic        bucket     = 1'b0;
	logic        aux_lock   = 1'b0;
	logic [18:0] cal        = 19'h00ABC;
	logic [18:0] integ      = 19'h01234;
	logic [18:0] prop       = 19'h00010;
	logic [18:0] man_f      = 19'h02222;
	logic [18:0] aux_f      = 19'h00777;
	logic [15:0] target     = 16'h0000;
	logic        ref_sel, src_val, ph_lock, track, disq, alarm, aux_lkd;
	logic [2:0]  code;
	logic [18:0] freq, avg, aux_fw;
	logic [15:0] ph_off;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc        = 0;
	int          n;
	tlm_row_s    rows [5]   = '{
		'{8'h10, 8'h80, 19'h02222},
		'{8'h10, 8'h00, 19'h02222},
		'{8'h00, 8'h00, 19'h01234},
		'{8'h00, 8'h80, 19'h00000},
		'{8'h00, 8'hC0, 19'h00000}
	};

	tlm_mode_ctrl #(
		.P_TICK_CYC     (10),
		.P_TIMEOUT_TICKS(20),
		.P_LOCK_TICKS   (5),
		.P_SLEW_WIN_CYC (8)
	) i_tlm_mode_ctrl (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_force_en(force_en), .i_force_code(force_code),
		.i_input_mode_cfg(in_mode), .i_holdover_mode_cfg(hold_mode), .i_phase_buildout_en(buildout_en),
		.i_freq_limit_ppm(freq_lim), .i_ref_selected(ref_sel), .i_src_valid(src_val),
		.i_standby_avail(standby), .i_phase_locked(ph_lock), .i_bucket_serious(bucket),
		.i_nominal_cal(cal), .i_loop_integral(integ), .i_loop_prop(prop), .i_man_holdover_freq(man_f),
		.i_phase_target(target), .i_aux_lock(aux_lock), .i_aux_loop_freq(aux_f),
		.o_main_loop_state_code(code), .o_track_ref(track), .o_ref_disqualify(disq),
		.o_phase_alarm(alarm), .o_freq_word(freq), .o_avg_freq(avg), .o_phase_offset(ph_off),
		.o_aux_locked(aux_lkd), .o_aux_freq_word(aux_fw)
	);

	tlm_ref_model i_tlm_ref_model (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_want_sel(want_sel), .i_want_valid(want_valid),
		.i_want_lock(want_lock), .i_disq(disq), .o_ref_selected(ref_sel), .o_src_valid(src_val),
		.o_phase_locked(ph_lock)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------------------------------
	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [18:0] seen, input logic [18:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wait_code(input logic [2:0] c, input int lim, output int cnt);
		cnt = 0;
		do begin
			step(1);
			cnt++;
		end while (code !== c && cnt < lim);
		chk(19'(code), 19'(c), "state code");
	endtask

	task automatic reselect();
		@(posedge clk);
		want_sel <= 1'b0;
		@(posedge clk);
		want_sel  <= 1'b1;
		want_lock <= 1'b1;
	endtask

	task automatic wait_move(input logic [15:0] old);
		n = 0;
		do begin
			step(1);
			n++;
		end while (ph_off === old && n < 20);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		step(5);
		chk(19'(code), 19'h0, "code in reset");
		@(posedge clk);
		rst_n <= 1'b1;
		step(3);
		chk(freq, cal, "free-run word");
		chk(19'(track), 19'h0, "free-run track");
		@(posedge clk);
		ce       <= 1'b0;
		want_sel <= 1'b1;
		step(6);
		chk(19'(code), 19'h0, "frozen by ce");
		@(posedge clk);
		ce <= 1'b1;
		wait_code(3'h3, 5, n);
		chk(19'(track), 19'h1, "prelocked track");
		wait_code(3'h0, 300, n);
		chk(19'({disq, alarm}), 19'h3, "prelocked timeout pulses");
		chk(19'(n >= 180 && n <= 215), 19'h1, "prelocked dwell");
		$display("test prelocked timeout done");
		reselect();
		wait_code(3'h3, 5, n);
		wait_code(3'h2, 100, n);
		chk(19'(n >= 40 && n <= 80), 19'h1, "lock qualify time");
		step(3);
		chk(freq, integ + prop, "locked word");
		@(posedge clk);
		want_lock <= 1'b0;
		wait_code(3'h5, 5, n);
		chk(19'(track), 19'h1, "lost-phase keeps tracking");
		@(posedge clk);
		standby <= 1'b1;
		bucket  <= 1'b1;
		wait_code(3'h4, 5, n);
		chk(19'({disq, alarm}), 19'h2, "bucket disqualify");
		@(posedge clk);
		standby <= 1'b0;
		bucket  <= 1'b0;
		wait_code(3'h1, 300, n);
		chk(19'({disq, alarm}), 19'h3, "prelocked2 timeout");
		chk(19'(n >= 180), 19'h1, "prelocked2 dwell");
		$display("test lock path done");
		@(posedge clk);
		integ <= 19'h05555;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			in_mode   <= rows[i].im;
			hold_mode <= rows[i].hm;
			step(3);
			chk(freq, rows[i].f, "holdover word");
		end
		chk(avg, 19'h0, "filter held outside locked");
		$display("test holdover rows done");
		reselect();
		wait_code(3'h4, 5, n);
		wait_code(3'h2, 100, n);
		@(posedge clk);
		want_lock <= 1'b0;
		wait_code(3'h5, 5, n);
		wait_code(3'h1, 300, n);
		chk(19'({disq, alarm}), 19'h3, "lost-phase timeout");
		reselect();
		wait_code(3'h4, 5, n);
		wait_code(3'h2, 100, n);
		@(posedge clk);
		want_valid <= 1'b0;
		wait_code(3'h1, 5, n);
		$display("test revisit done");
		@(posedge clk);
		want_valid <= 1'b1;
		want_sel   <= 1'b0;
		force_en   <= 1'b1;
		force_code <= 3'h2;
		wait_code(3'h2, 5, n);
		@(posedge clk);
		force_code <= 3'h7;
		step(5);
		chk(19'(code), 19'h2, "force code refused");
		@(posedge clk);
		force_code <= 3'h0;
		wait_code(3'h0, 5, n);
		@(posedge clk);
		force_en <= 1'b0;
		step(3);
		chk(19'({aux_lkd, 16'h0}) | aux_fw, 19'h0, "aux start");
		@(posedge clk);
		aux_lock <= 1'b1;
		step(3);
		chk(aux_fw, aux_f, "aux locked word");
		@(posedge clk);
		target <= 16'h0064;
		step(3);
		chk(19'(ph_off), 19'h00064, "phase follows");
		@(posedge clk);
		buildout_en <= 1'b1;
		target <= 16'h0190;
		wait_move(16'h0064);
		chk(19'(ph_off), 19'h000B5, "buildout slew");
		@(posedge clk);
		buildout_en <= 1'b0;
		freq_lim <= 8'h14;
		wait_move(16'h00B5);
		chk(19'(ph_off), 19'h00106, "limit slew");
		@(posedge clk);
		target <= 16'h0000;
		wait_move(16'h0106);
		chk(19'(ph_off), 19'h000B5, "limit slew down");
		$display("test force aux slew done");
		@(posedge clk);
		rst_n <= 1'b0;
		step(2);
		chk(19'(code) | freq, 19'h0, "mid-run reset");
		@(posedge clk);
		rst_n <= 1'b1;
		step(2);
		chk(freq, cal, "free-run after reset");
		$display("test reset done");
		test_done();
	end
endmodule
